/* rtl/mas_map.vh */
// Constants for the skip and subtract execution block: register
// offsets, instruction word fields, opcodes and reset values.
// Assumes the block sits on a 32-bit APB with a 12-bit byte address.
// Functional notes
// RQ1 - Rotate right through carry into accumulator
// RQ2 - Subtract with borrow into accumulator, four flags
// RQ3 - Subtract with borrow into memory, four flags
// RQ4 - Decrement memory, skip when zero, flags kept
// RQ5 - Decrement into accumulator, skip when zero
// RQ6 - Skip discards next instruction, dummy cycle
// RQ7 - Set byte writes all ones, flags kept
// RQ8 - Set bit forces selected bit only
// RQ9 - Increment memory, skip when wrapped zero
// RQ10 - Increment into accumulator, skip when zero
// RQ11 - Skip when selected memory bit set
// RQ12 - Subtract memory into accumulator, four flags
// RQ13 - Subtract memory into memory, four flags
// RQ14 - Subtract immediate into accumulator, four flags
// RQ15 - Swap memory nibbles in place
// RQ16 - Carry, aux carry, zero, overflow from adder
`ifndef MAS_MAP_VH
`define MAS_MAP_VH

// Register byte offsets
`define MAS_OFF_INSTR 12'h000
`define MAS_OFF_NEXT 12'h004
`define MAS_OFF_ACC 12'h008
`define MAS_OFF_FLAGS 12'h00C
`define MAS_OFF_EXEC 12'h010
`define MAS_OFF_COUNT 12'h014
`define MAS_MEM_PAGE 4'h1

// Instruction word fields
`define MAS_F_OP 3:0
`define MAS_F_BIT 6:4
`define MAS_F_IMM 15:8
`define MAS_F_ADDR 23:16

// Flag register bit positions
`define MAS_FL_C 0
`define MAS_FL_AUX 1
`define MAS_FL_Z 2
`define MAS_FL_OVF 3

// Opcodes
`define MAS_OP_ROTATE_RIGHT_CARRY_TO_ACC 4'h0
`define MAS_OP_SUBTRACT_WITH_BORROW 4'h1
`define MAS_OP_SUBTRACT_WITH_BORROW_TO_MEM 4'h2
`define MAS_OP_DECREMENT_SKIP_IF_ZERO 4'h3
`define MAS_OP_DECREMENT_TO_ACC_SKIP_IF_ZERO 4'h4
`define MAS_OP_SETBYTE 4'h5
`define MAS_OP_SETBIT 4'h6
`define MAS_OP_INCREMENT_SKIP_IF_ZERO 4'h7
`define MAS_OP_INCREMENT_TO_ACC_SKIP_IF_ZERO 4'h8
`define MAS_OP_SKIP_IF_BIT_SET 4'h9
`define MAS_OP_SUB 4'hA
`define MAS_OP_SUBTRACT_TO_MEM 4'hB
`define MAS_OP_SUBI 4'hC
`define MAS_OP_SWAP 4'hD

// Reset values and cycle counts
`define MAS_ACC_RST 8'h00
`define MAS_FLAGS_RST 4'h0
`define MAS_INSTR_RST 32'h00000000
`define MAS_CYC_PLAIN 2'h1
`define MAS_CYC_SKIP 2'h2

`endif

/* rtl/mas_dmem.v */
// Byte-wide data memory with one combinational read port and one
// synchronous write port. Assumes the caller muxes the two users.
`timescale 1ns/1ps
module mas_dmem #(
	parameter DEPTH = 16,
	parameter AW = 4
)(
	input wire pclk,
	input wire presetn,
	input wire [AW-1:0] raddr,
	output wire [7:0] rdata,
	input wire we,
	input wire [AW-1:0] waddr,
	input wire [7:0] wdata
);
	reg [7:0] mem [0:DEPTH-1];
	integer i;

	// Read is combinational so an instruction completes in one cycle
	assign rdata = mem[raddr];

	// Cleared at reset so reads never return unknowns
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (i = 0; i < DEPTH; i = i + 1)
				mem[i] <= 8'h00;
		end
		else if (we)
		begin
			mem[waddr] <= wdata;
		end
	end
endmodule

/* rtl/mas_sub8.v */
// Eight-bit subtractor a + ~b + cin with its four status outputs.
// Purely combinational; the caller decides which flags to keep.
`timescale 1ns/1ps
module mas_sub8 (
	input wire [7:0] a,
	input wire [7:0] b,
	input wire cin,
	output wire [7:0] res,
	output wire carry,
	output wire aux_carry,
	output wire zero,
	output wire overflow
);
	wire [7:0] nb;
	wire [8:0] sum;
	wire [4:0] low;

	// RQ16 carry out of bit 7
	assign nb = ~b;
	assign sum = {1'b0, a} + {1'b0, nb} + {8'h00, cin};
	assign res = sum[7:0];
	assign carry = sum[8];
	// RQ16 carry out of bit 3
	assign low = {1'b0, a[3:0]} + {1'b0, nb[3:0]} + {4'h0, cin};
	assign aux_carry = low[4];
	// RQ16 zero and signed overflow
	assign zero = (sum[7:0] == 8'h00);
	assign overflow = (a[7] == nb[7]) && (sum[7] != a[7]);
endmodule

/* rtl/mas_top.v */
// Execution block for rotate, subtract, skip, set and swap
// instructions, with an APB register file in front of it.
// Assumes a 32-bit APB master; all accesses wait while an
// instruction or its dummy cycle is in progress.
`timescale 1ns/1ps
`include "mas_map.vh"
module mas_top #(
	parameter DEPTH = 16,
	parameter AW = 4
)(
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr
);
	localparam ST_IDLE = 3'b001;
	localparam ST_EXEC = 3'b010;
	localparam ST_DUMMY = 3'b100;

	reg [2:0] state;
	reg [31:0] cur_instr, next_instr;
	reg [7:0] accumulator;
	reg next_valid, carry_flag, aux_carry_flag, zero_flag, overflow_flag;
	reg skip_taken, next_discarded, illegal_seen;
	reg [1:0] last_cycles;
	reg [15:0] exec_count, skip_count;

	wire [3:0] cur_op;
	wire [2:0] cur_bit;
	wire [7:0] cur_imm, cur_addr, dmem_q, mem_rd, bit_mask, sub_b, sub_res, dmem_wdata;
	wire addr_ok, sub_cin, sub_c, sub_aux, sub_z, sub_ovf, use_borrow;
	wire acc_phase, done, bus_wr, is_idle, hit, exec_mem_we, dmem_we;
	wire sel_mem, sel_instr, sel_next, sel_acc, sel_flags, sel_exec, sel_count;
	wire [AW-1:0] bus_idx, dmem_addr;

	// Combinational decode results
	reg [7:0] next_res;
	reg wr_mem, wr_acc, upd_arith, upd_c, next_c, take_skip, illegal;
	reg [31:0] next_prdata;

	// Instruction word fields
	assign cur_op = cur_instr[`MAS_F_OP];
	assign cur_bit = cur_instr[`MAS_F_BIT];
	assign cur_imm = cur_instr[`MAS_F_IMM];
	assign cur_addr = cur_instr[`MAS_F_ADDR];
	assign addr_ok = ({24'h000000, cur_addr} < DEPTH);
	assign bit_mask = 8'h01 << cur_bit;

	// Out-of-range operands read as zero rather than aliasing
	assign mem_rd = addr_ok ? dmem_q : 8'h00;

	// APB phase decode
	assign acc_phase = psel & penable;
	assign done = acc_phase & pready;
	assign bus_wr = done & pwrite;
	assign is_idle = (state == ST_IDLE);

	// Address decode; low two address bits are ignored in the memory page only
	assign bus_idx = paddr[AW+1:2];
	assign sel_mem = (paddr[11:8] == `MAS_MEM_PAGE) && ({26'h0, paddr[7:2]} < DEPTH);
	assign sel_instr = (paddr == `MAS_OFF_INSTR);
	assign sel_next = (paddr == `MAS_OFF_NEXT);
	assign sel_acc = (paddr == `MAS_OFF_ACC);
	assign sel_flags = (paddr == `MAS_OFF_FLAGS);
	assign sel_exec = (paddr == `MAS_OFF_EXEC);
	assign sel_count = (paddr == `MAS_OFF_COUNT);
	assign hit = sel_mem | sel_instr | sel_next | sel_acc | sel_flags | sel_exec | sel_count;

	// Borrow variants feed the carry flag in; plain subtracts feed one
	assign use_borrow = (cur_op == `MAS_OP_SUBTRACT_WITH_BORROW) ||
		(cur_op == `MAS_OP_SUBTRACT_WITH_BORROW_TO_MEM);
	// RQ14 immediate operand selected
	assign sub_b = (cur_op == `MAS_OP_SUBI) ? cur_imm : mem_rd;
	// RQ2 carry in from flag
	assign sub_cin = use_borrow ? carry_flag : 1'b1;

	mas_sub8 u_sub (
		.a(accumulator), .b(sub_b), .cin(sub_cin), .res(sub_res),
		.carry(sub_c), .aux_carry(sub_aux), .zero(sub_z), .overflow(sub_ovf)
	);

	// Operation decode for the instruction in the execute cycle
	always @*
	begin
		next_res = mem_rd;
		wr_mem = 1'b0;
		wr_acc = 1'b0;
		upd_arith = 1'b0;
		upd_c = 1'b0;
		next_c = carry_flag;
		take_skip = 1'b0;
		illegal = 1'b0;
		case (cur_op)
			`MAS_OP_ROTATE_RIGHT_CARRY_TO_ACC:
			begin
				// RQ1 rotate through carry
				next_res = {carry_flag, mem_rd[7:1]};
				next_c = mem_rd[0];
				wr_acc = 1'b1;
				upd_c = 1'b1;
			end
			`MAS_OP_SUBTRACT_WITH_BORROW:
			begin
				// RQ2 result to accumulator
				next_res = sub_res;
				wr_acc = 1'b1;
				upd_arith = 1'b1;
			end
			`MAS_OP_SUBTRACT_WITH_BORROW_TO_MEM:
			begin
				// RQ3 result to memory
				next_res = sub_res;
				wr_mem = 1'b1;
				upd_arith = 1'b1;
			end
			`MAS_OP_DECREMENT_SKIP_IF_ZERO:
			begin
				// RQ4 decrement in place
				next_res = mem_rd - 8'h01;
				wr_mem = 1'b1;
				take_skip = (mem_rd == 8'h01);
			end
			`MAS_OP_DECREMENT_TO_ACC_SKIP_IF_ZERO:
			begin
				// RQ5 decrement to accumulator
				next_res = mem_rd - 8'h01;
				wr_acc = 1'b1;
				take_skip = (mem_rd == 8'h01);
			end
			`MAS_OP_SETBYTE:
			begin
				// RQ7 all ones
				next_res = 8'hFF;
				wr_mem = 1'b1;
			end
			`MAS_OP_SETBIT:
			begin
				// RQ8 force one bit
				next_res = mem_rd | bit_mask;
				wr_mem = 1'b1;
			end
			`MAS_OP_INCREMENT_SKIP_IF_ZERO:
			begin
				// RQ9 increment in place
				next_res = mem_rd + 8'h01;
				wr_mem = 1'b1;
				take_skip = (mem_rd == 8'hFF);
			end
			`MAS_OP_INCREMENT_TO_ACC_SKIP_IF_ZERO:
			begin
				// RQ10 increment to accumulator
				next_res = mem_rd + 8'h01;
				wr_acc = 1'b1;
				take_skip = (mem_rd == 8'hFF);
			end
			`MAS_OP_SKIP_IF_BIT_SET:
			begin
				// RQ11 test selected bit
				take_skip = ((mem_rd & bit_mask) != 8'h00);
			end
			`MAS_OP_SUB:
			begin
				// RQ12 memory subtract
				next_res = sub_res;
				wr_acc = 1'b1;
				upd_arith = 1'b1;
			end
			`MAS_OP_SUBTRACT_TO_MEM:
			begin
				// RQ13 subtract into memory
				next_res = sub_res;
				wr_mem = 1'b1;
				upd_arith = 1'b1;
			end
			`MAS_OP_SUBI:
			begin
				// RQ14 immediate subtract
				next_res = sub_res;
				wr_acc = 1'b1;
				upd_arith = 1'b1;
			end
			`MAS_OP_SWAP:
			begin
				// RQ15 exchange nibbles
				next_res = {mem_rd[3:0], mem_rd[7:4]};
				wr_mem = 1'b1;
			end
			default:
				illegal = 1'b1;
		endcase
	end

	// Memory port sharing; bus and execution never overlap in time
	assign exec_mem_we = (state == ST_EXEC) & wr_mem & addr_ok;
	assign dmem_we = exec_mem_we | (bus_wr & sel_mem & is_idle);
	assign dmem_addr = (state == ST_EXEC) ? cur_addr[AW-1:0] : bus_idx;
	assign dmem_wdata = (state == ST_EXEC) ? next_res : pwdata[7:0];

	mas_dmem #(
		.DEPTH(DEPTH),
		.AW(AW)
	) u_dmem (
		.pclk(pclk),
		.presetn(presetn),
		.raddr(dmem_addr),
		.rdata(dmem_q),
		.we(dmem_we),
		.waddr(dmem_addr),
		.wdata(dmem_wdata)
	);

	// Sequencer, accumulator, flags and execution status
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= ST_IDLE;
			cur_instr <= `MAS_INSTR_RST;
			next_instr <= `MAS_INSTR_RST;
			next_valid <= 1'b0;
			accumulator <= `MAS_ACC_RST;
			carry_flag <= 1'b0;
			aux_carry_flag <= 1'b0;
			zero_flag <= 1'b0;
			overflow_flag <= 1'b0;
			skip_taken <= 1'b0;
			next_discarded <= 1'b0;
			illegal_seen <= 1'b0;
			last_cycles <= 2'h0;
			exec_count <= 16'h0000;
			skip_count <= 16'h0000;
		end
		else
		begin
			case (state)
				ST_IDLE:
				begin
					if (bus_wr && sel_instr)
					begin
						cur_instr <= pwdata;
						skip_taken <= 1'b0;
						next_discarded <= 1'b0;
						illegal_seen <= 1'b0;
						state <= ST_EXEC;
					end
					if (bus_wr && sel_next)
					begin
						next_instr <= pwdata;
						next_valid <= 1'b1;
					end
					if (bus_wr && sel_acc)
						accumulator <= pwdata[7:0];
					if (bus_wr && sel_flags)
					begin
						carry_flag <= pwdata[`MAS_FL_C];
						aux_carry_flag <= pwdata[`MAS_FL_AUX];
						zero_flag <= pwdata[`MAS_FL_Z];
						overflow_flag <= pwdata[`MAS_FL_OVF];
					end
					if (bus_wr && sel_count)
					begin
						exec_count <= 16'h0000;
						skip_count <= 16'h0000;
					end
				end
				ST_EXEC:
				begin
					exec_count <= exec_count + 16'h0001;
					if (illegal)
						illegal_seen <= 1'b1;
					if (wr_acc)
						accumulator <= next_res;
					// RQ1 only carry changes
					if (upd_c)
						carry_flag <= next_c;
					// RQ16 four flags from adder
					if (upd_arith)
					begin
						carry_flag <= sub_c;
						aux_carry_flag <= sub_aux;
						zero_flag <= sub_z;
						overflow_flag <= sub_ovf;
					end
					// RQ6 discard fetched instruction
					if (take_skip)
					begin
						skip_taken <= 1'b1;
						skip_count <= skip_count + 16'h0001;
						last_cycles <= `MAS_CYC_SKIP;
						next_discarded <= next_valid;
						next_valid <= 1'b0;
						state <= ST_DUMMY;
					end
					else if (next_valid)
					begin
						// Prefetched word runs straight on
						last_cycles <= `MAS_CYC_PLAIN;
						cur_instr <= next_instr;
						next_valid <= 1'b0;
						state <= ST_EXEC;
					end
					else
					begin
						last_cycles <= `MAS_CYC_PLAIN;
						state <= ST_IDLE;
					end
				end
				ST_DUMMY:
					// RQ6 dummy second cycle
					state <= ST_IDLE;
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	// Read data for every mapped register
	always @*
	begin
		next_prdata = 32'h00000000;
		if (sel_instr)
			next_prdata = cur_instr;
		else if (sel_next)
			next_prdata = next_instr;
		else if (sel_acc)
			next_prdata = {24'h000000, accumulator};
		else if (sel_flags)
			next_prdata = {28'h0000000, overflow_flag, zero_flag,
				aux_carry_flag, carry_flag};
		else if (sel_exec)
			next_prdata = {22'h000000, last_cycles, 3'h0, illegal_seen,
				next_valid, next_discarded, skip_taken, ~is_idle};
		else if (sel_count)
			next_prdata = {skip_count, exec_count};
		else if (sel_mem)
			next_prdata = {24'h000000, dmem_q};
	end

	// APB answer: one wait state, held off while an instruction runs
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else if (done)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else if (acc_phase && is_idle)
		begin
			pready <= 1'b1;
			pslverr <= ~hit; // Unmapped address answers with an error
			prdata <= pwrite ? 32'h00000000 : next_prdata;
		end
	end
endmodule

/* testbench/mas_top_asserts.sv */
// Checker for the skip and subtract block, watching APB ports only.
// Assumes the bind in the bench and the offsets of mas_map.vh.
`timescale 1ns/1ps
`include "mas_map.vh"
module mas_top_asserts #(
	parameter DEPTH = 16,
	parameter AW = 4
)(
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [11:0] paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic pready,
	input logic pslverr
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Completed read of one offset
	sequence s_rd(logic [11:0] off);
		psel && penable && pready && !pwrite && paddr == off;
	endsequence
	// Completed read of a mapped word (index below DEPTH) in the data memory page
	sequence s_mem_rd;
		psel && penable && pready && !pwrite && paddr[11:8] == `MAS_MEM_PAGE && paddr[7:2] < DEPTH;
	endsequence
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	a_ready_access: assert property (pready |-> psel && penable)
		else $error("pready outside an access phase");
	a_skip_two: assert property (s_rd(`MAS_OFF_EXEC) ##0 prdata[1] |-> prdata[9:8] == 2'h2)
		else $error("skip without two cycles");
	a_discard_skip: assert property (s_rd(`MAS_OFF_EXEC) ##0 prdata[2] |-> prdata[1])
		else $error("next discarded without skip");
	a_cycles_legal: assert property (s_rd(`MAS_OFF_EXEC) |-> prdata[9:8] != 2'h3)
		else $error("cycle count out of range");
	a_flags_width: assert property (s_rd(`MAS_OFF_FLAGS) |-> prdata[31:4] == 28'h0)
		else $error("flag register upper bits set");
	a_acc_byte: assert property (s_rd(`MAS_OFF_ACC) |-> prdata[31:8] == 24'h0)
		else $error("accumulator wider than a byte");
	a_mem_byte: assert property (s_mem_rd |-> prdata[31:8] == 24'h0 && !pslverr)
		else $error("memory read not a clean byte");
endmodule

/* testbench/mas_apb_master.sv */
// APB master model: one blocking transfer task for the bench.
// Assumes the caller has waited out reset before the first call.
`timescale 1ns/1ps
module mas_apb_master (
	input logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic pready,
	input logic pslverr
);
	// Idle bus from time zero
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
	end
	// Leading edge keeps psel low a cycle, so no double drive
	task xfer(input logic w, logic [11:0] a, logic [31:0] d, output logic [31:0] q, logic e);
		begin
			@(posedge pclk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			@(posedge pclk);
			while (pready !== 1'b1)
				@(posedge pclk);
			q = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
endmodule

/* testbench/mas_top_bench.sv */
// Bench for the skip and subtract block: table of instructions.
// Assumes mas_apb_master and mas_top_asserts are compiled first.
`timescale 1ns/1ps
`include "mas_map.vh"
module mas_top_bench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic e;
	int err_total = 0;
	int comparisons = 0;
	always #20 pclk = ~pclk;
	mas_apb_master i_mst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	mas_top #(.DEPTH(16), .AW(4)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	task chk(input string n, logic [31:0] x, logic [31:0] g);
		begin
			comparisons++;
			if (g !== x)
			begin
				err_total++;
				$display("[ERR] %s expected %h seen %h", n, x, g);
			end
		end
	endtask
	task stop_test;
		begin
			$display("checks %0d errors %0d", comparisons, err_total);
			if (err_total == 0 && comparisons > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	task wr(input logic [11:0] a, logic [31:0] d);
		i_mst.xfer(1'b1, a, d, q, e);
	endtask
	task rd(input logic [11:0] a);
		begin
			i_mst.xfer(1'b0, a, 32'h00000000, q, e);
			chk("pslverr", 32'h00000000, {31'h0, e});
		end
	endtask
	function logic [11:0] ma(input logic [3:0] i);
		ma = {`MAS_MEM_PAGE, 2'b00, i, 2'b00};
	endfunction
	// Load operands, run one instruction, compare memory, acc, flags, cycles
	task t(input logic [3:0] op, logic [7:0] x, logic [3:0] a, logic [7:0] m, acc, logic [3:0] fl,
		logic [7:0] em, ea, logic [3:0] ef, logic [1:0] ec);
		begin
			wr(ma(a), {24'h0, m});
			wr(`MAS_OFF_ACC, {24'h0, acc});
			wr(`MAS_OFF_FLAGS, {28'h0, fl});
			wr(`MAS_OFF_INSTR, {12'h000, a, x, 1'b0, x[2:0], op});
			rd(ma(a));
			chk("mem", {24'h0, em}, q);
			rd(`MAS_OFF_ACC);
			chk("acc", {24'h0, ea}, q);
			rd(`MAS_OFF_FLAGS);
			chk("flags", {28'h0, ef}, q);
			rd(`MAS_OFF_EXEC);
			chk("cycles", {30'h0, ec}, {30'h0, q[9:8]});
			chk("skip", {31'h0, ec == 2'h2}, {31'h0, q[1]});
		end
	endtask
	// Watchdog far beyond the roughly 730 cycles the table needs
	initial
	begin
		repeat (20000) @(posedge pclk);
		err_total++;
		stop_test;
	end
	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd(`MAS_OFF_ACC);
		chk("acc reset", 32'h00000000, q);
		i_mst.xfer(1'b0, 12'h300, 32'h00000000, q, e);
		chk("unmapped err", 32'h00000001, {31'h0, e});
		t(`MAS_OP_ROTATE_RIGHT_CARRY_TO_ACC, 8'h00, 4'h1, 8'hA5, 8'h00, 4'hE, 8'hA5, 8'h52, 4'hF, 2'h1);
		t(`MAS_OP_ROTATE_RIGHT_CARRY_TO_ACC, 8'h00, 4'h1, 8'h02, 8'h00, 4'h1, 8'h02, 8'h81, 4'h0, 2'h1);
		t(`MAS_OP_SUBTRACT_WITH_BORROW, 8'h00, 4'h2, 8'h01, 8'h10, 4'h0, 8'h01, 8'h0E, 4'h1, 2'h1);
		t(`MAS_OP_SUBTRACT_WITH_BORROW_TO_MEM, 8'h00, 4'h3, 8'h01, 8'h80, 4'h1, 8'h7F, 8'h80, 4'h9, 2'h1);
		t(`MAS_OP_SUB, 8'h00, 4'h4, 8'h05, 8'h05, 4'h0, 8'h05, 8'h00, 4'h7, 2'h1);
		t(`MAS_OP_SUBTRACT_TO_MEM, 8'h00, 4'h5, 8'h01, 8'h00, 4'hF, 8'hFF, 8'h00, 4'h0, 2'h1);
		t(`MAS_OP_SUBI, 8'hFF, 4'h6, 8'h00, 8'h7F, 4'h0, 8'h00, 8'h80, 4'hA, 2'h1);
		t(`MAS_OP_DECREMENT_SKIP_IF_ZERO, 8'h00, 4'h7, 8'h01, 8'h00, 4'h5, 8'h00, 8'h00, 4'h5, 2'h2);
		t(`MAS_OP_DECREMENT_SKIP_IF_ZERO, 8'h00, 4'h7, 8'h00, 8'h00, 4'h5, 8'hFF, 8'h00, 4'h5, 2'h1);
		t(`MAS_OP_DECREMENT_TO_ACC_SKIP_IF_ZERO, 8'h00, 4'h8, 8'h01, 8'h33, 4'hA, 8'h01, 8'h00, 4'hA, 2'h2);
		t(`MAS_OP_INCREMENT_SKIP_IF_ZERO, 8'h00, 4'h9, 8'hFF, 8'h00, 4'h3, 8'h00, 8'h00, 4'h3, 2'h2);
		t(`MAS_OP_INCREMENT_TO_ACC_SKIP_IF_ZERO, 8'h00, 4'hA, 8'hFF, 8'h00, 4'hC, 8'hFF, 8'h00, 4'hC, 2'h2);
		t(`MAS_OP_INCREMENT_TO_ACC_SKIP_IF_ZERO, 8'h00, 4'hA, 8'h7F, 8'h00, 4'h0, 8'h7F, 8'h80, 4'h0, 2'h1);
		t(`MAS_OP_SETBYTE, 8'h00, 4'hB, 8'h00, 8'h00, 4'h6, 8'hFF, 8'h00, 4'h6, 2'h1);
		t(`MAS_OP_SETBIT, 8'h07, 4'hC, 8'h00, 8'h00, 4'h9, 8'h80, 8'h00, 4'h9, 2'h1);
		t(`MAS_OP_SETBIT, 8'h03, 4'hC, 8'hF0, 8'h00, 4'h0, 8'hF8, 8'h00, 4'h0, 2'h1);
		t(`MAS_OP_SKIP_IF_BIT_SET, 8'h02, 4'hD, 8'h04, 8'h00, 4'h0, 8'h04, 8'h00, 4'h0, 2'h2);
		t(`MAS_OP_SKIP_IF_BIT_SET, 8'h02, 4'hD, 8'hFB, 8'h00, 4'h0, 8'hFB, 8'h00, 4'h0, 2'h1);
		t(`MAS_OP_SWAP, 8'h00, 4'hF, 8'h3C, 8'h00, 4'h0, 8'hC3, 8'h00, 4'h0, 2'h1);
		// Prefetched set byte is dropped after a skip, run otherwise
		wr(ma(4'h2), 32'h00000000);
		wr(`MAS_OFF_NEXT, {8'h00, 8'h02, 12'h000, `MAS_OP_SETBYTE});
		t(`MAS_OP_INCREMENT_SKIP_IF_ZERO, 8'h00, 4'h0, 8'hFF, 8'h00, 4'h0, 8'h00, 8'h00, 4'h0, 2'h2);
		rd(ma(4'h2));
		chk("discarded", 32'h00000000, q);
		wr(`MAS_OFF_NEXT, {8'h00, 8'h02, 12'h000, `MAS_OP_SETBYTE});
		t(`MAS_OP_INCREMENT_SKIP_IF_ZERO, 8'h00, 4'h0, 8'h10, 8'h00, 4'h0, 8'h11, 8'h00, 4'h0, 2'h1);
		rd(ma(4'h2));
		chk("chained", 32'h000000FF, q);
		rd(`MAS_OFF_NEXT);
		chk("next word", {8'h00, 8'h02, 12'h000, `MAS_OP_SETBYTE}, q);
		// Undefined opcode runs as a flagged one-cycle no-op
		wr(`MAS_OFF_INSTR, 32'h0000000E);
		rd(`MAS_OFF_EXEC);
		chk("exec illegal", 32'h00000110, q);
		// Six skips among twenty-three executed words so far
		rd(`MAS_OFF_COUNT);
		chk("count", 32'h00060017, q);
		wr(`MAS_OFF_COUNT, 32'h00000000);
		rd(`MAS_OFF_COUNT);
		chk("count clear", 32'h00000000, q);
		stop_test;
	end
endmodule
bind mas_top mas_top_asserts #(.DEPTH(DEPTH), .AW(AW)) i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr));
